/* rtl/spx_map.svh */
// constants for the stack push/pop execution block
`ifndef SPX_MAP_SVH
`define SPX_MAP_SVH
`define SPX_OP_PUSH_DIR 8'h70
`define SPX_OP_PUSH_IND 8'h71
`define SPX_OP_USER_PUSH_DEC 8'h82
`define SPX_OP_USER_POP_DEC 8'h92
`define SPX_OP_USER_POP_INC 8'h93
`define SPX_LEN_PUSH 4'h2
`define SPX_LEN_USER 4'h3
`define SPX_CYCLES 4'h8
`define SPX_SP_RESET 16'h0000
`endif

/* rtl/spx_pkg.sv */
// types for the stack push/pop execution block
package spx_pkg;
  typedef enum logic [2:0] {
    SPX_IDLE = 3'b000,
    SPX_PTR = 3'b001,
    SPX_XFER = 3'b010,
    SPX_UPD = 3'b011,
    SPX_WAIT = 3'b100
  } spx_state_t;
  typedef enum logic [2:0] {
    SPX_K_PUSH_DIR = 3'b000,
    SPX_K_PUSH_IND = 3'b001,
    SPX_K_USER_PUSH_DEC = 3'b010,
    SPX_K_USER_POP_DEC = 3'b011,
    SPX_K_USER_POP_INC = 3'b100
  } spx_kind_t;
endpackage

/* rtl/spx_exec.sv */
// stack push/pop execution unit with its own register file and stack memory
// What this block does
// RULE1 - pop-decrement 92: copy addressed register to destination, then pointer minus one
// RULE2 - pop-increment 93: copy addressed register to destination, then pointer plus one
// RULE3 - system push 70/71: stack pointer minus one, then write source there
// RULE4 - push-decrement: pointer minus one first, then store source at new pointer
// RULE5 - push-decrement is three bytes, eight cycles, dst indirect, src direct
// RULE6 - no stack instruction changes any condition flag
// RULE7 - system stack pointer is one 16-bit value, zero wraps to all ones
// RULE8 - user stack pointer is any general register named indirectly
// RULE9 - user pointer arithmetic is eight bit, wrapping modulo 256
`timescale 1ns/10ps
`include "spx_map.svh"
module spx_exec
  import spx_pkg::*;
#(
  parameter int STACK_AW = 16
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] op1_i,
  input wire logic [7:0] op2_i,
  input wire logic [5:0] flags_i,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output logic [3:0] length_o,
  output logic [5:0] flags_o,
  output logic [15:0] sp_o,
  input wire logic [7:0] dbg_addr_i,
  output logic [7:0] dbg_data_o,
  input wire logic [7:0] dbg_stack_addr_i,
  output logic [7:0] dbg_stack_data_o
);
  logic [7:0] regs_q [0:255];
  logic [7:0] stack_q [0:255];
  spx_state_t state_reg, state_next;
  spx_kind_t kind_reg, kind_next;
  logic [7:0] a1_reg, a1_next, a2_reg, a2_next, ptr_reg, ptr_next;
  logic [15:0] sp_reg, sp_next;
  logic [3:0] cnt_reg, cnt_next, len_reg, len_next;
  logic [5:0] flags_reg, flags_next;
  logic done_reg, done_next, ill_reg, ill_next;
  logic rf_we, st_we;
  logic [7:0] rf_wa, rf_wd, st_wd;

  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    a1_next = a1_reg;
    a2_next = a2_reg;
    ptr_next = ptr_reg;
    sp_next = sp_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    flags_next = flags_reg;
    done_next = 1'b0;
    ill_next = 1'b0;
    rf_we = 1'b0;
    rf_wa = 8'h00;
    rf_wd = 8'h00;
    st_we = 1'b0;
    st_wd = 8'h00;
    case (state_reg)
      SPX_IDLE:
      begin
        if (start_i)
        begin
          a1_next = op1_i;
          a2_next = op2_i;
          flags_next = flags_i; // [RULE6]
          cnt_next = 4'h1;
          state_next = SPX_PTR;
          case (opcode_i)
            `SPX_OP_PUSH_DIR:
            begin
              kind_next = SPX_K_PUSH_DIR;
              len_next = `SPX_LEN_PUSH; // [RULE3]
            end
            `SPX_OP_PUSH_IND:
            begin
              kind_next = SPX_K_PUSH_IND;
              len_next = `SPX_LEN_PUSH; // [RULE3]
            end
            `SPX_OP_USER_PUSH_DEC:
            begin
              kind_next = SPX_K_USER_PUSH_DEC;
              len_next = `SPX_LEN_USER; // [RULE5]
            end
            `SPX_OP_USER_POP_DEC:
            begin
              kind_next = SPX_K_USER_POP_DEC;
              len_next = `SPX_LEN_USER;
            end
            `SPX_OP_USER_POP_INC:
            begin
              kind_next = SPX_K_USER_POP_INC;
              len_next = `SPX_LEN_USER;
            end
            default:
            begin
              ill_next = 1'b1;
              state_next = SPX_IDLE;
            end
          endcase
        end
      end
      SPX_PTR:
      begin
        cnt_next = cnt_reg + 4'h1;
        state_next = SPX_XFER;
        case (kind_reg)
          // operand order: push-decrement gives dst then src, system pushes give src alone, pops give src then dst
          SPX_K_PUSH_DIR: ptr_next = regs_q[a1_reg];
          SPX_K_PUSH_IND: ptr_next = regs_q[regs_q[a1_reg]];
          SPX_K_USER_PUSH_DEC: ptr_next = regs_q[a1_reg] - 8'h01; // [RULE4] [RULE8] [RULE9]
          default: ptr_next = regs_q[a1_reg]; // [RULE8]
        endcase
        if (kind_reg == SPX_K_PUSH_DIR || kind_reg == SPX_K_PUSH_IND)
          sp_next = sp_reg - 16'h0001; // [RULE3] [RULE7]
        if (kind_reg == SPX_K_USER_PUSH_DEC)
        begin
          rf_we = 1'b1; // [RULE4]
          rf_wa = a1_reg;
          rf_wd = regs_q[a1_reg] - 8'h01;
        end
      end
      SPX_XFER:
      begin
        cnt_next = cnt_reg + 4'h1;
        state_next = SPX_UPD;
        case (kind_reg)
          SPX_K_PUSH_DIR, SPX_K_PUSH_IND:
          begin
            st_we = 1'b1; // [RULE3]
            st_wd = ptr_reg;
          end
          SPX_K_USER_PUSH_DEC:
          begin
            rf_we = 1'b1; // [RULE4]
            rf_wa = ptr_reg;
            rf_wd = regs_q[a2_reg];
          end
          default:
          begin
            rf_we = 1'b1; // [RULE1] [RULE2]
            rf_wa = a2_reg;
            rf_wd = regs_q[ptr_reg];
          end
        endcase
      end
      SPX_UPD:
      begin
        cnt_next = cnt_reg + 4'h1;
        state_next = SPX_WAIT;
        // pointer written after the data so a pop into its own pointer ends with the update
        if (kind_reg == SPX_K_USER_POP_DEC || kind_reg == SPX_K_USER_POP_INC)
        begin
          rf_we = 1'b1;
          rf_wa = a1_reg;
          rf_wd = (kind_reg == SPX_K_USER_POP_DEC) ? regs_q[a1_reg] - 8'h01 // [RULE1] [RULE9]
                                            : regs_q[a1_reg] + 8'h01; // [RULE2] [RULE9]
        end
      end
      SPX_WAIT:
      begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == `SPX_CYCLES - 4'h1) // [RULE5]
        begin
          done_next = 1'b1;
          state_next = SPX_IDLE;
        end
      end
      default: state_next = SPX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= SPX_IDLE;
      kind_reg <= SPX_K_PUSH_DIR;
      a1_reg <= 8'h00;
      a2_reg <= 8'h00;
      ptr_reg <= 8'h00;
      sp_reg <= `SPX_SP_RESET;
      cnt_reg <= 4'h0;
      len_reg <= 4'h0;
      flags_reg <= 6'h00;
      done_reg <= 1'b0;
      ill_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      a1_reg <= a1_next;
      a2_reg <= a2_next;
      ptr_reg <= ptr_next;
      sp_reg <= sp_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      flags_reg <= flags_next;
      done_reg <= done_next;
      ill_reg <= ill_next;
    end
  end

  // register file resets to its own addresses so every pointer is known after reset
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < 256; i++)
        regs_q[i] <= 8'(i);
    end
    else if (rf_we)
      regs_q[rf_wa] <= rf_wd;
  end

  // stack memory carries no reset; it is only read where a push wrote it
  always_ff @(posedge ref_clk_i)
  begin
    if (st_we)
      stack_q[sp_reg[7:0]] <= st_wd; // only the low stack byte is backed by storage
  end

  assign busy_o = (state_reg != SPX_IDLE);
  assign done_o = done_reg;
  assign illegal_o = ill_reg;
  assign length_o = len_reg;
  assign flags_o = flags_reg;
  assign sp_o = sp_reg;
  assign dbg_data_o = regs_q[dbg_addr_i];
  assign dbg_stack_data_o = stack_q[dbg_stack_addr_i];

  sp_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE3] [RULE7]
    (state_reg == SPX_PTR && kind_reg inside {SPX_K_PUSH_DIR, SPX_K_PUSH_IND})
    |=> sp_reg == $past(sp_reg) - 16'h0001) else $error("push did not decrement sp");
  op_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE5]
    $rose(busy_o) |-> ##6 !done_o ##1 done_o) else $error("instruction not eight cycles");
  flags_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE6]
    busy_o && $past(busy_o) |-> $stable(flags_o)) else $error("flags changed");
  push_order_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE3]
    st_we |-> $past(state_reg) == SPX_PTR) else $error("stack written before sp update");
  // the pointer fetched in the first step is the reference, unless the pop overwrote it
  pop_dec_upd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE1]
    (state_reg == SPX_UPD && kind_reg == SPX_K_USER_POP_DEC)
    |-> rf_we && rf_wa == a1_reg && (a2_reg == a1_reg || rf_wd == ptr_reg - 8'h01))
    else $error("pop-dec pointer wrong");
  pop_inc_upd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE2]
    (state_reg == SPX_UPD && kind_reg == SPX_K_USER_POP_INC)
    |-> rf_we && rf_wa == a1_reg && (a2_reg == a1_reg || rf_wd == ptr_reg + 8'h01))
    else $error("pop-inc pointer wrong");
  push_dec_ptr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE4]
    (state_reg == SPX_PTR && kind_reg == SPX_K_USER_PUSH_DEC)
    |-> rf_we && rf_wa == a1_reg ##1 ptr_reg == $past(regs_q[a1_reg]) - 8'h01)
    else $error("push-dec pointer wrong");
  pop_xfer_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE8]
    (state_reg == SPX_XFER && kind_reg inside {SPX_K_USER_POP_DEC, SPX_K_USER_POP_INC})
    |-> rf_we && rf_wa == a2_reg ##1 state_reg == SPX_UPD) else $error("pop transfer wrong");
  user_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [RULE5]
    busy_o && kind_reg == SPX_K_USER_PUSH_DEC && state_reg != SPX_IDLE && $past(busy_o)
    |-> length_o == 4'h3) else $error("push-dec length not three");
endmodule // spx_exec

/* test/spx_mem_model.sv */
// reference model of the register file, stack memory and system stack pointer
`timescale 1ns/10ps
module spx_mem_model;
  // register cells start at their own address as after reset; stack cells stay unknown
  logic [7:0] rf [256];
  logic [7:0] st [256];
  logic [15:0] sp = 16'h0000;

  initial
  begin
    for (int i = 0; i < 256; i++)
      rf[i] = 8'(i);
  end

  task automatic exec(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    case (op)
      8'h70, 8'h71:
      begin
        sp = sp - 16'h0001;
        st[sp[7:0]] = (op == 8'h70) ? rf[a] : rf[rf[a]];
      end
      8'h82:
      begin
        p = rf[a] - 8'h01;
        rf[a] = p;
        rf[p] = rf[b];
      end
      8'h92, 8'h93:
      begin
        p = rf[a];
        rf[b] = rf[p];
        // pointer re-read after the data lands, so a pop into its own pointer steps that value
        rf[a] = (op == 8'h92) ? rf[a] - 8'h01 : rf[a] + 8'h01;
      end
      default: ;
    endcase
  endtask
endmodule // spx_mem_model

/* test/spx_exec_test.sv */
// self-checking testbench for the stack push/pop execution unit
`timescale 1ns/10ps
module spx_exec_test;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic start_i = 1'b0;
  logic [7:0] opcode_i = 8'h00;
  logic [7:0] op1_i = 8'h00;
  logic [7:0] op2_i = 8'h00;
  logic [5:0] flags_i = 6'h00;
  logic [7:0] dbg_addr_i = 8'h00;
  logic [7:0] dbg_stack_addr_i = 8'h00;
  logic busy_o, done_o, illegal_o;
  logic [3:0] length_o;
  logic [5:0] flags_o;
  logic [15:0] sp_o;
  logic [7:0] dbg_data_o, dbg_stack_data_o;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] rnd = 32'hb36a;
  logic [7:0] ops [5] = '{8'h70, 8'h71, 8'h82, 8'h92, 8'h93};
  int n;

  spx_mem_model M();
  spx_exec DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
    .opcode_i(opcode_i), .op1_i(op1_i), .op2_i(op2_i), .flags_i(flags_i),
    .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .length_o(length_o),
    .flags_o(flags_o), .sp_o(sp_o), .dbg_addr_i(dbg_addr_i), .dbg_data_o(dbg_data_o),
    .dbg_stack_addr_i(dbg_stack_addr_i), .dbg_stack_data_o(dbg_stack_data_o));

  always #25 ref_clk_i = ~ref_clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // inputs move on the rising edge; outputs are read 1 ns later, once settled
  // hold keeps start up one cycle into the busy unit, which must ignore it
  task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
    input logic hold);
    logic [5:0] f;
    logic [7:0] x;
    rnd = lfsr(rnd);
    f = rnd[5:0];
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    opcode_i <= op;
    op1_i <= a;
    op2_i <= b;
    flags_i <= f;
    @(posedge ref_clk_i);
    start_i <= hold;
    #1;
    M.exec(op, a, b);
    n = 1;
    while (done_o !== 1'b1 && n < 12)
    begin
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      #1;
      n++;
    end
    chk("cycles", 16'd8, 16'(n));
    chk("busy at done", 16'h0, {15'h0, busy_o});
    chk("flags", {10'h0, f}, {10'h0, flags_o});
    chk("length", (op[7:4] == 4'h7) ? 16'h2 : 16'h3, {12'h0, length_o});
    chk("sp", M.sp, sp_o);
    x = (op == 8'h82) ? M.rf[a] : b;
    dbg_addr_i <= a;
    dbg_stack_addr_i <= M.sp[7:0];
    #1;
    chk("pointer", {8'h0, M.rf[a]}, {8'h0, dbg_data_o});
    chk("stack", {8'h0, M.st[M.sp[7:0]]}, {8'h0, dbg_stack_data_o});
    dbg_addr_i <= x;
    #1;
    chk("reg", {8'h0, M.rf[x]}, {8'h0, dbg_data_o});
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk("sp reset", 16'h0000, sp_o);
    run(8'h70, 8'h40, 8'h00, 1'b0);
    run(8'h82, 8'h00, 8'h40, 1'b0);
    run(8'h71, 8'h00, 8'h00, 1'b1);
    run(8'h93, 8'h00, 8'h01, 1'b0);
    run(8'h92, 8'h03, 8'h02, 1'b0);
    run(8'h93, 8'h05, 8'h05, 1'b0);
    for (int i = 0; i < 40; i++)
    begin
      rnd = lfsr(rnd);
      run(ops[rnd[31:8] % 5], rnd[7:0], rnd[15:8], rnd[16]);
    end
    // unknown opcode: one illegal pulse, never busy, pointer untouched
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    opcode_i <= 8'h50;
    n = 0;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      #1;
      n = n + (illegal_o === 1'b1) + 4 * (busy_o !== 1'b0);
    end
    chk("illegal", 16'h1, 16'(n));
    chk("sp kept", M.sp, sp_o);
    tally_and_finish();
  end
endmodule // spx_exec_test
